// *** verilog/fanout_defines.svh ***
// Offsets, field positions, reset values and timing counts of the fanout control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FANOUT_DEFINES_SVH
`define FANOUT_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define FO_ADDR_W 12
`define FO_OFF_CTRL 12'h000
`define FO_OFF_DIV 12'h004
`define FO_OFF_STATUS 12'h008

// ****************************************
// Fields
// ****************************************
`define FO_CTRL_SEL_BIT 0
`define FO_CTRL_EN_BIT 1
`define FO_CTRL_RESET 32'h0000_0003
`define FO_DIV_RESET 8'h00
`define FO_ST_SEL_BIT 0
`define FO_ST_GUARD_BIT 1
`define FO_ST_EN_BIT 2
`define FO_ST_READY_BIT 3

// ****************************************
// Timing
// ****************************************
`define FO_BANKS 4
`define FO_SYNC_EDGES 3'h4
`define FO_EN_STAGES 3

`endif

// *** verilog/fanout_pkg.sv ***
// Types shared by the fanout control block and its bank dividers.
// Assumes the defines header is on the include path.
`include "fanout_defines.svh"

package fanout_pkg;

  // ****************************************
  // Bus carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`FO_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  // ****************************************
  // Modes and registers
  // ****************************************
  typedef enum logic [1:0] {
    DIV_BY1,
    DIV_BY2,
    DIV_BY4
  } div_sel_type;

  typedef enum logic [1:0] {
    REG_CTRL,
    REG_DIV,
    REG_STATUS,
    REG_NONE
  } reg_sel_type;

endpackage

// *** verilog/bank_divider.sv ***
// One output bank divider: divides the selected clock by one, two or four.
// Assumes tick_in marks a rising edge of the selected clock in the clk_in domain.
`timescale 1ns/100ps
`include "fanout_defines.svh"

module bank_divider (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic lvl_in,
  input wire fanout_pkg::div_sel_type mode_in,
  output logic lvl_out,
  output logic idle_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] cnt;
  } div_state_type;

  div_state_type state_r;
  div_state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (clear_in) begin
      state_nxt.cnt = 2'h0;
    end else if (tick_in) begin
      state_nxt.cnt = state_r.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bank level by mode
  always_comb begin
    case (mode_in)
      fanout_pkg::DIV_BY2: lvl_out = state_r.cnt[0];
      fanout_pkg::DIV_BY4: lvl_out = state_r.cnt[1];
      default: lvl_out = lvl_in;
    endcase
  end

  assign idle_out = (state_r.cnt == 2'h0);

endmodule

// *** verilog/clock_fanout_output_control.sv ***
// Output control of a two-input clock fanout with four divided banks, APB registers.
// Assumes reference clocks and pin levels are asynchronous to clk_in.
`timescale 1ns/100ps
`include "fanout_defines.svh"

module clock_fanout_output_control (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire fanout_pkg::apb_req_type apb_in,
  output fanout_pkg::apb_rsp_type apb_out,
  input wire logic ref_a_in,
  input wire logic ref_b_in,
  input wire logic swing_a_ok_in,
  input wire logic swing_b_ok_in,
  input wire logic output_reset_n_in,
  output logic [`FO_BANKS-1:0] q_out,
  output logic [`FO_BANKS-1:0] qn_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    fanout_pkg::apb_rsp_type rsp;
    logic sel_req;
    logic en_req;
    logic [7:0] div_cfg;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] ok_a;
    logic [1:0] ok_b;
    logic prev_lvl;
    logic sel_cur;
    logic [`FO_EN_STAGES-1:0] en_chain;
  } core_state_type;

  typedef struct packed {
    logic [2:0] hold_cnt;
    logic [`FO_BANKS-1:0] q;
    logic [`FO_BANKS-1:0] qn;
  } out_state_type;

  core_state_type core_r;
  core_state_type core_nxt;
  out_state_type out_r;
  out_state_type out_nxt;

  logic lvl;
  logic sig_ok;
  logic tick;
  logic ready;
  logic all_idle;
  logic out_rst;
  logic [`FO_BANKS-1:0] bank_lvl;
  logic [`FO_BANKS-1:0] bank_idle;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic fanout_pkg::reg_sel_type reg_decode(input logic [`FO_ADDR_W-1:0] addr);
    case (addr)
      `FO_OFF_CTRL: reg_decode = fanout_pkg::REG_CTRL;
      `FO_OFF_DIV: reg_decode = fanout_pkg::REG_DIV;
      `FO_OFF_STATUS: reg_decode = fanout_pkg::REG_STATUS;
      default: reg_decode = fanout_pkg::REG_NONE;
    endcase
  endfunction

  // ****************************************
  // Selected clock
  // ****************************************
  assign lvl = core_r.sel_cur ? core_r.sync_a[1] : core_r.sync_b[1];
  assign sig_ok = core_r.sel_cur ? core_r.ok_a[1] : core_r.ok_b[1];
  assign tick = lvl & ~core_r.prev_lvl & sig_ok;
  assign ready = (out_r.hold_cnt == `FO_SYNC_EDGES);
  assign all_idle = &bank_idle;
  assign out_rst = rst_in | ~output_reset_n_in;

  // ****************************************
  // Bank dividers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `FO_BANKS; gi++) begin : g_bank
      bank_divider u_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(~ready),
        .tick_in(tick),
        .lvl_in(lvl),
        .mode_in(fanout_pkg::div_sel_type'(core_r.div_cfg[2*gi +: 2])),
        .lvl_out(bank_lvl[gi]),
        .idle_out(bank_idle[gi])
      );
    end
  endgenerate

  // ****************************************
  // Core logic
  // ****************************************
  always_comb begin
    fanout_pkg::reg_sel_type rs;
    rs = reg_decode(apb_in.paddr);
    core_nxt = core_r;
    core_nxt.sync_a = {core_r.sync_a[0], ref_a_in};
    core_nxt.sync_b = {core_r.sync_b[0], ref_b_in};
    core_nxt.ok_a = {core_r.ok_a[0], swing_a_ok_in};
    core_nxt.ok_b = {core_r.ok_b[0], swing_b_ok_in};
    core_nxt.prev_lvl = lvl;
    // Switch only with all banks at count zero and the clock low or its input invalid
    if ((core_r.sel_req != core_r.sel_cur) && all_idle && (~lvl || ~sig_ok)) begin
      core_nxt.sel_cur = core_r.sel_req;
      core_nxt.prev_lvl = core_r.sel_req ? core_r.sync_a[1] : core_r.sync_b[1];
    end
    if (tick) begin
      core_nxt.en_chain = {core_r.en_chain[`FO_EN_STAGES-2:0], core_r.en_req};
    end
    // APB setup: answer in the following access cycle
    if (apb_in.psel && !apb_in.penable && !core_r.rsp.pready) begin
      core_nxt.rsp.pready = 1'b1;
      core_nxt.rsp.pslverr = (rs == fanout_pkg::REG_NONE);
      core_nxt.rsp.prdata = 32'h0000_0000;
      if (!apb_in.pwrite) begin
        case (rs)
          fanout_pkg::REG_CTRL: begin
            core_nxt.rsp.prdata[`FO_CTRL_SEL_BIT] = core_r.sel_req;
            core_nxt.rsp.prdata[`FO_CTRL_EN_BIT] = core_r.en_req;
          end
          fanout_pkg::REG_DIV: core_nxt.rsp.prdata[7:0] = core_r.div_cfg;
          fanout_pkg::REG_STATUS: begin
            core_nxt.rsp.prdata[`FO_ST_SEL_BIT] = core_r.sel_cur;
            core_nxt.rsp.prdata[`FO_ST_GUARD_BIT] = ~sig_ok;
            core_nxt.rsp.prdata[`FO_ST_EN_BIT] = core_r.en_chain[`FO_EN_STAGES-1];
            core_nxt.rsp.prdata[`FO_ST_READY_BIT] = ready;
          end
          default: core_nxt.rsp.prdata = 32'h0000_0000;
        endcase
      end
    end else if (apb_in.psel && apb_in.penable && core_r.rsp.pready) begin
      core_nxt.rsp.pready = 1'b0;
      core_nxt.rsp.pslverr = 1'b0;
      if (apb_in.pwrite) begin
        case (rs)
          fanout_pkg::REG_CTRL: begin
            core_nxt.sel_req = apb_in.pwdata[`FO_CTRL_SEL_BIT];
            core_nxt.en_req = apb_in.pwdata[`FO_CTRL_EN_BIT];
          end
          fanout_pkg::REG_DIV: core_nxt.div_cfg = apb_in.pwdata[7:0];
          default: core_nxt.div_cfg = core_r.div_cfg;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_r <= '0;
      core_r.sel_req <= 1'(`FO_CTRL_RESET >> `FO_CTRL_SEL_BIT);
      core_r.en_req <= 1'(`FO_CTRL_RESET >> `FO_CTRL_EN_BIT);
      core_r.div_cfg <= `FO_DIV_RESET;
      core_r.sel_cur <= 1'b1;
    end else begin
      core_r <= core_nxt;
    end
  end

  // ****************************************
  // Output stage
  // ****************************************
  always_comb begin
    out_nxt = out_r;
    if (sig_ok) begin
      if (!ready) begin
        if (tick) begin
          out_nxt.hold_cnt = out_r.hold_cnt + 3'h1;
        end
        out_nxt.q = '0;
      end else if (core_r.en_chain[`FO_EN_STAGES-1]) begin
        out_nxt.q = bank_lvl;
      end else begin
        out_nxt.q = '0;
      end
      out_nxt.qn = ~out_nxt.q;
    end
    // Without a valid input the outputs are held as they stand
  end

  always_ff @(posedge clk_in or posedge out_rst) begin
    if (out_rst) begin
      out_r.hold_cnt <= 3'h0;
      out_r.q <= '0;
      out_r.qn <= '1;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign q_out = out_r.q;
  assign qn_out = out_r.qn;
  assign apb_out = core_r.rsp;

endmodule

// *** test/fanout_sva.sv ***
// Port checker of the fanout control block.
// Assumes a bind from the testbench top.
`timescale 1ns/100ps
`include "fanout_defines.svh"
module fanout_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire fanout_pkg::apb_req_type apb_in,
  input wire fanout_pkg::apb_rsp_type apb_out,
  input wire logic swing_a_ok_in,
  input wire logic swing_b_ok_in,
  input wire logic output_reset_n_in,
  input wire logic [`FO_BANKS-1:0] q_out,
  input wire logic [`FO_BANKS-1:0] qn_out
);
  localparam int EN_MAX = 80;
  logic setup;
  logic off_wr;
  assign setup = apb_in.psel && !apb_in.penable;
  assign off_wr = apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite &&
    apb_in.paddr == 12'h000 && !apb_in.pwdata[1] && swing_a_ok_in && swing_b_ok_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_ORST_FORCE: assert property (
    !output_reset_n_in |-> q_out == 4'h0 && qn_out == 4'hF) else $error("no output reset");
  AST_ORST_HOLD: assert property (
    $rose(output_reset_n_in) |-> (q_out == 4'h0)[*4]) else $error("reset left early");
  AST_COMPL: assert property (
    q_out == ~qn_out) else $error("pair mismatch");
  AST_FROZEN: assert property (
    (!swing_a_ok_in && !swing_b_ok_in && output_reset_n_in)[*6] |-> $stable(q_out))
    else $error("outputs moved without input");
  AST_EN_OFF: assert property (
    off_wr |-> ##[1:EN_MAX] (q_out == 4'h0)[*8]) else $error("disable too slow");
  AST_RDY: assert property (
    setup |=> apb_out.pready) else $error("no ready after setup");
  AST_RDY_PULSE: assert property (
    apb_out.pready |=> !apb_out.pready) else $error("ready too long");
  AST_ERR: assert property (
    setup && apb_in.paddr > 12'h008 |=> apb_out.pslverr) else $error("no slave error");
endmodule

// *** test/clk_source.sv ***
// Model of the two reference clock sources.
// Assumes fail_in changes just after a rising clock edge.
`timescale 1ns/100ps
module clk_source #(parameter int HALF_A = 4, parameter int HALF_B = 6) (
  input wire logic clk_in,
  input wire logic fail_in,
  output logic ref_a_out,
  output logic ref_b_out,
  output logic swing_a_ok_out,
  output logic swing_b_ok_out
);
  int ca = 0;
  int cb = 0;
  logic ra = 1'h0;
  logic rb = 1'h0;
  // A failed source stops static and drops its amplitude flag
  always @(posedge clk_in) begin
    ca <= (ca + 1) % HALF_A;
    cb <= (cb + 1) % HALF_B;
    if (ca == HALF_A - 1 && !fail_in) ra <= !ra;
    if (cb == HALF_B - 1 && !fail_in) rb <= !rb;
  end
  assign ref_a_out = ra;
  assign ref_b_out = rb;
  assign swing_a_ok_out = !fail_in;
  assign swing_b_ok_out = !fail_in;
endmodule

// *** test/tb_top.sv ***
// Testbench top: APB master, source model, scoreboard queues.
// Assumes package, defines header, design, model and checker compiled first.
`timescale 1ns/100ps
`include "fanout_defines.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb_top;
  typedef struct {int b; int v;} note_type;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic output_reset_n_in = 1'h1;
  logic fail = 1'h0;
  logic ref_a_in, ref_b_in, swing_a_ok_in, swing_b_ok_in;
  logic [`FO_BANKS-1:0] q_out, qn_out, q_d;
  logic [32:0] e;
  logic [31:0] divv;
  logic [32:0] aq[$];
  note_type oq[$];
  int n_fail = 0;
  int checks_done = 0;
  int per[4];
  int cnt[4];
  event ev;
  fanout_pkg::apb_req_type apb_in = '0;
  fanout_pkg::apb_rsp_type apb_out;
  initial forever #5 clk_in = ~clk_in;
  clock_fanout_output_control u_clock_fanout_output_control (.*);
  clk_source u_clk_source (.clk_in(clk_in), .fail_in(fail), .ref_a_out(ref_a_in),
    .ref_b_out(ref_b_in), .swing_a_ok_out(swing_a_ok_in), .swing_b_ok_out(swing_b_ok_in));
  // Output period meter and APB response scoreboard
  always @(posedge clk_in) begin
    q_d <= q_out;
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= q_out[i] && !q_d[i] ? 1 : cnt[i] + 1;
      if (q_out[i] && !q_d[i]) per[i] <= cnt[i];
    end
    if (apb_out.pready === 1'h1 && apb_in.psel && apb_in.penable) begin
      e = aq.pop_front();
      `CHK(apb_out.pslverr, e[32])
      if (!apb_in.pwrite) `CHK(apb_out.prdata, e[31:0])
    end
  end
  always @(ev) begin
    note_type n;
    n = oq.pop_front();
    if (n.b < 0) `CHK({qn_out, q_out}, n.v[7:0])
    else `CHK(per[n.b], n.v)
  end
  task automatic wrap_up();
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] x);
    int k;
    k = 0;
    aq.push_back(x);
    @(posedge clk_in) apb_in <= '{1'h1, 1'h0, w, a, d};
    @(posedge clk_in) apb_in.penable <= 1'h1;
    do begin
      @(posedge clk_in);
      k++;
    end while (apb_out.pready !== 1'h1 && k < 20);
    apb_in.psel <= 1'h0;
    apb_in.penable <= 1'h0;
    if (apb_out.pready !== 1'h1) begin
      n_fail++;
      wrap_up();
    end
  endtask
  function automatic int fdiv(logic [1:0] c);
    return c == 2'h1 ? 2 : c == 2'h2 ? 4 : 1;
  endfunction
  task automatic banks(int p);
    for (int i = 0; i < 4; i++) begin
      oq.push_back('{i, p * fdiv(divv[2*i+:2])});
      @(negedge clk_in) -> ev;
    end
  endtask
  task automatic lvl();
    oq.push_back('{-1, 8'hF0});
    @(negedge clk_in) -> ev;
  endtask
  initial begin
    void'($urandom(19));
    divv = 32'h0000_0000;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'h0;
    apb(1'h0, 12'h000, 32'h0, 33'h0_0000_0003);
    apb(1'h0, 12'h004, 32'h0, 33'h0_0000_0000);
    repeat (200) @(posedge clk_in);
    apb(1'h0, 12'h008, 32'h0, 33'h0_0000_000D);
    banks(8);
    for (int k = 0; k < 2; k++) begin
      divv = k ? {24'h00_0000, 8'($urandom)} : 32'h0000_00E4;
      apb(1'h1, 12'h004, divv, 33'h0);
      apb(1'h0, 12'h004, 32'h0, {1'h0, divv});
      repeat (300) @(posedge clk_in);
      banks(8);
    end
    apb(1'h0, 12'h00C, 32'h0, 33'h1_0000_0000);
    apb(1'h1, 12'h00C, 32'hFFFF_FFFF, 33'h1_0000_0000);
    apb(1'h1, 12'h008, 32'h0, 33'h0);
    apb(1'h1, 12'h000, 32'h0000_0001, 33'h0);
    repeat (50) @(posedge clk_in);
    lvl();
    apb(1'h1, 12'h000, 32'h0000_0003, 33'h0);
    repeat (200) @(posedge clk_in);
    output_reset_n_in <= 1'h0;
    lvl();
    repeat (10) @(posedge clk_in);
    output_reset_n_in <= 1'h1;
    lvl();
    repeat (200) @(posedge clk_in);
    apb(1'h0, 12'h008, 32'h0, 33'h0_0000_000D);
    fail <= 1'h1;
    repeat (20) @(posedge clk_in);
    apb(1'h0, 12'h008, 32'h0, 33'h0_0000_000F);
    fail <= 1'h0;
    apb(1'h1, 12'h000, 32'h0000_0002, 33'h0);
    repeat (300) @(posedge clk_in);
    apb(1'h0, 12'h008, 32'h0, 33'h0_0000_000C);
    banks(12);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    wrap_up();
  end
endmodule
bind clock_fanout_output_control fanout_sva u_fanout_sva (.*);
